// File: include/ism_pkg.sv
package ism_pkg;

    // ********************************************************************
    // Register bus
    // ********************************************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] OFF_STATUS   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_MASK     = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_OWN      = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_RXD      = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_TXD      = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h7;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ism_req_type;

    // ********************************************************************
    // Field layouts and reset values
    // ********************************************************************
    localparam int ST_TBF   = 0;
    localparam int ST_RBF   = 1;
    localparam int ST_RW    = 2;
    localparam int ST_START = 3;
    localparam int ST_STOP  = 4;

    localparam int MASK_W = 10;
    localparam logic [MASK_W-1:0] MASK_RST = 10'h000;
    localparam logic [MASK_W-1:0] OWN_RST  = 10'h000;

    localparam int CTRL_W   = 2;
    localparam int CTRL_EN  = 0;
    localparam int CTRL_TEN = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

    localparam int IRQ_W     = 5;
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP  = 1;
    localparam int IRQ_MATCH = 2;
    localparam int IRQ_RX    = 3;
    localparam int IRQ_TX    = 4;
    localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

    // ********************************************************************
    // Serial framing
    // ********************************************************************
    localparam logic [3:0]        BYTE_BITS  = 4'h8;
    localparam logic [4:0]        TEN_PREFIX = 5'h1e;
    localparam logic [MASK_W-1:0] VALID_7    = 10'h07f;
    localparam logic [MASK_W-1:0] VALID_HI   = 10'h300;
    localparam logic [MASK_W-1:0] VALID_LO   = 10'h0ff;

    typedef enum logic [3:0] {
        s_idle,
        s_addr,
        s_addr2,
        s_rx,
        s_ack,
        s_tx,
        s_tx_ack,
        s_wait
    } ism_fsm_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } ism_line_type;

    typedef struct packed {
        ism_fsm_type       fsm;
        ism_fsm_type       after;
        logic [MASK_W-1:0] mask;
        logic [MASK_W-1:0] own;
        logic [CTRL_W-1:0] ctrl;
        logic [7:0]        rx_hold;
        logic [7:0]        tx_hold;
        logic [7:0]        shift;
        logic [3:0]        bitcnt;
        logic              start_flag;
        logic              stop_flag;
        logic              rw_flag;
        logic              receive_full_flag;
        logic              transmit_full_flag;
        logic              ten_hi_ok;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic [DATA_W-1:0] rdata;
        logic              sda_oe;
        logic              irq;
    } ism_state_type;

endpackage

// File: rtl/ism_line_watch.sv
module ism_line_watch
(
    input  wire logic            clock,
    input  wire logic            rst,
    input  wire logic            scl_pin,
    input  wire logic            sda_pin,
    output ism_pkg::ism_line_type line
);

    // ********************************************************************
    // Pin synchronisers and condition detect
    // ********************************************************************
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
    } ism_watch_type;

    ism_watch_type s;
    ism_watch_type next_s;

    always_comb
    begin
        next_s    = s;
        next_s.s1 = {sda_pin, scl_pin};
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Only the second and third stages are looked at
    always_comb
    begin
        line.scl      = s.s2[0];
        line.sda      = s.s2[1];
        line.scl_rise = s.s2[0] & ~s.s3[0];
        line.scl_fall = ~s.s2[0] & s.s3[0];
        line.start    = s.s2[0] & s.s3[0] & s.s3[1] & ~s.s2[1];
        line.stop     = s.s2[0] & s.s3[0] & ~s.s3[1] & s.s2[1];
    end

endmodule // ism_line_watch

// File: rtl/ism_top.sv
// Functional notes
// - Start flag set on Start or Repeated Start, cleared on Stop.
// - Slave direction flag updated once the address byte is received; 1 means read.
// - Receive-full flag set when a received byte enters the receive holding register.
// - Software read of the receive holding register clears receive-full.
// - Software write of the transmit holding register sets transmit-full.
// - Transmit-full clears when the data byte has been shifted out.
// - Mask bit one: that incoming address bit is ignored in the compare.
// - Mask bit zero: incoming address bit must equal the own address bit.
// - Upper six bits of the address mask register read as zero.
module ism_top
(
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire ism_pkg::ism_req_type        bus_req,
    output logic [ism_pkg::DATA_W-1:0]       bus_rdata,
    input  wire logic                        scl_pin,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    output logic                             irq
);

    ism_pkg::ism_state_type s;
    ism_pkg::ism_state_type next_s;
    ism_pkg::ism_line_type  line;

    ism_line_watch u_line_watch
    (
        .clock   (clock),
        .rst     (rst),
        .scl_pin (scl_pin),
        .sda_pin (sda_in),
        .line    (line)
    );

    // ********************************************************************
    // Masked address compare
    // ********************************************************************
    // Positions outside the active width never block a match
    function automatic logic addr_match
    (
        input logic [ism_pkg::MASK_W-1:0] incoming,
        input logic [ism_pkg::MASK_W-1:0] own,
        input logic [ism_pkg::MASK_W-1:0] mask,
        input logic [ism_pkg::MASK_W-1:0] valid
    );
        addr_match = &(~(incoming ^ own) | mask | ~valid);
    endfunction

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb
    begin
        next_s = s;

        // Software clears first so that hardware sets below win
        next_s.rdata = '0;
        if (bus_req.rd)
        begin
            if (bus_req.addr == ism_pkg::OFF_STATUS)
            begin
                next_s.rdata[ism_pkg::ST_TBF]   = s.transmit_full_flag;
                next_s.rdata[ism_pkg::ST_RBF]   = s.receive_full_flag;
                next_s.rdata[ism_pkg::ST_RW]    = s.rw_flag;
                next_s.rdata[ism_pkg::ST_START] = s.start_flag;
                next_s.rdata[ism_pkg::ST_STOP]  = s.stop_flag;
            end
            else if (bus_req.addr == ism_pkg::OFF_MASK)
            begin
                next_s.rdata[ism_pkg::MASK_W-1:0] = s.mask;
            end
            else if (bus_req.addr == ism_pkg::OFF_OWN)
            begin
                next_s.rdata[ism_pkg::MASK_W-1:0] = s.own;
            end
            else if (bus_req.addr == ism_pkg::OFF_CTRL)
            begin
                next_s.rdata[ism_pkg::CTRL_W-1:0] = s.ctrl;
            end
            else if (bus_req.addr == ism_pkg::OFF_RXD)
            begin
                next_s.rdata[7:0] = s.rx_hold;
                next_s.receive_full_flag        = 1'b0;
            end
            else if (bus_req.addr == ism_pkg::OFF_IRQ_STAT)
            begin
                next_s.rdata[ism_pkg::IRQ_W-1:0] = s.irq_stat;
            end
            else if (bus_req.addr == ism_pkg::OFF_IRQ_MASK)
            begin
                next_s.rdata[ism_pkg::IRQ_W-1:0] = s.irq_mask;
            end
        end

        if (bus_req.wr)
        begin
            if (bus_req.addr == ism_pkg::OFF_MASK)
            begin
                next_s.mask = bus_req.wdata[ism_pkg::MASK_W-1:0];
            end
            else if (bus_req.addr == ism_pkg::OFF_OWN)
            begin
                next_s.own = bus_req.wdata[ism_pkg::MASK_W-1:0];
            end
            else if (bus_req.addr == ism_pkg::OFF_CTRL)
            begin
                next_s.ctrl = bus_req.wdata[ism_pkg::CTRL_W-1:0];
            end
            else if (bus_req.addr == ism_pkg::OFF_TXD)
            begin
                next_s.tx_hold = bus_req.wdata[7:0];
            end
            else if (bus_req.addr == ism_pkg::OFF_IRQ_STAT)
            begin
                next_s.irq_stat = s.irq_stat & ~bus_req.wdata[ism_pkg::IRQ_W-1:0];
            end
            else if (bus_req.addr == ism_pkg::OFF_IRQ_MASK)
            begin
                next_s.irq_mask = bus_req.wdata[ism_pkg::IRQ_W-1:0];
            end
        end

        // ****************************************************************
        // Serial slave engine
        // ****************************************************************
        if (!s.ctrl[ism_pkg::CTRL_EN])
        begin
            next_s.fsm    = ism_pkg::s_idle;
            next_s.sda_oe = 1'b0;
        end
        else if (line.start)
        begin
            next_s.start_flag = 1'b1;
            next_s.stop_flag  = 1'b0;
            next_s.fsm        = ism_pkg::s_addr;
            next_s.bitcnt     = '0;
            next_s.sda_oe     = 1'b0;
            next_s.irq_stat[ism_pkg::IRQ_START] = 1'b1;
        end
        else if (line.stop)
        begin
            next_s.start_flag = 1'b0;
            next_s.stop_flag  = 1'b1;
            next_s.fsm        = ism_pkg::s_idle;
            next_s.sda_oe     = 1'b0;
            next_s.ten_hi_ok  = 1'b0;
            next_s.irq_stat[ism_pkg::IRQ_STOP] = 1'b1;
        end
        else
        begin
            case (s.fsm)
                ism_pkg::s_addr, ism_pkg::s_addr2, ism_pkg::s_rx:
                begin
                    if (line.scl_rise && s.bitcnt != ism_pkg::BYTE_BITS)
                    begin
                        next_s.shift  = {s.shift[6:0], line.sda};
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end
                    else if (line.scl_fall && s.bitcnt == ism_pkg::BYTE_BITS)
                    begin
                        // Unmatched or refused bytes wait out the frame
                        next_s.fsm    = ism_pkg::s_wait;
                        next_s.bitcnt = '0;
                        if (s.fsm == ism_pkg::s_addr && s.ctrl[ism_pkg::CTRL_TEN])
                        begin
                            if (s.shift[7:3] == ism_pkg::TEN_PREFIX
                                && addr_match({s.shift[2:1], 8'h00}, s.own, s.mask,
                                              ism_pkg::VALID_HI))
                            begin
                                if (!s.shift[0])
                                begin
                                    next_s.fsm    = ism_pkg::s_ack;
                                    next_s.after  = ism_pkg::s_addr2;
                                    next_s.sda_oe = 1'b1;
                                end
                                else if (s.ten_hi_ok)
                                begin
                                    next_s.rw_flag = 1'b1;
                                    next_s.fsm     = ism_pkg::s_ack;
                                    next_s.after   = ism_pkg::s_tx;
                                    next_s.sda_oe  = 1'b1;
                                    next_s.irq_stat[ism_pkg::IRQ_MATCH] = 1'b1;
                                end
                            end
                        end
                        else if (s.fsm == ism_pkg::s_addr)
                        begin
                            if (addr_match({3'h0, s.shift[7:1]}, s.own, s.mask,
                                           ism_pkg::VALID_7))
                            begin
                                next_s.rw_flag = s.shift[0];
                                next_s.fsm     = ism_pkg::s_ack;
                                next_s.after   = s.shift[0] ? ism_pkg::s_tx : ism_pkg::s_rx;
                                next_s.sda_oe  = 1'b1;
                                next_s.irq_stat[ism_pkg::IRQ_MATCH] = 1'b1;
                            end
                        end
                        else if (s.fsm == ism_pkg::s_addr2)
                        begin
                            if (addr_match({2'h0, s.shift}, s.own, s.mask,
                                           ism_pkg::VALID_LO))
                            begin
                                next_s.ten_hi_ok = 1'b1;
                                next_s.rw_flag   = 1'b0;
                                next_s.fsm       = ism_pkg::s_ack;
                                next_s.after     = ism_pkg::s_rx;
                                next_s.sda_oe    = 1'b1;
                                next_s.irq_stat[ism_pkg::IRQ_MATCH] = 1'b1;
                            end
                        end
                        else if (!s.receive_full_flag)
                        begin
                            // A full holding register is never overwritten: no ack
                            next_s.rx_hold = s.shift;
                            next_s.receive_full_flag     = 1'b1;
                            next_s.fsm     = ism_pkg::s_ack;
                            next_s.after   = ism_pkg::s_rx;
                            next_s.sda_oe  = 1'b1;
                            next_s.irq_stat[ism_pkg::IRQ_RX] = 1'b1;
                        end
                    end
                end

                ism_pkg::s_ack:
                begin
                    if (line.scl_fall)
                    begin
                        next_s.fsm    = s.after;
                        next_s.bitcnt = '0;
                        next_s.sda_oe = 1'b0;
                        if (s.after == ism_pkg::s_tx)
                        begin
                            next_s.shift  = s.tx_hold;
                            next_s.sda_oe = ~s.tx_hold[7];
                        end
                    end
                end

                ism_pkg::s_tx:
                begin
                    if (line.scl_rise)
                    begin
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end
                    else if (line.scl_fall && s.bitcnt == ism_pkg::BYTE_BITS)
                    begin
                        next_s.sda_oe = 1'b0;
                        next_s.transmit_full_flag    = 1'b0;
                        next_s.fsm    = ism_pkg::s_tx_ack;
                        next_s.irq_stat[ism_pkg::IRQ_TX] = 1'b1;
                    end
                    else if (line.scl_fall)
                    begin
                        next_s.shift  = {s.shift[6:0], 1'b0};
                        next_s.sda_oe = ~s.shift[6];
                    end
                end

                ism_pkg::s_tx_ack:
                begin
                    if (line.scl_rise)
                    begin
                        // Master ack asks for another byte; nack ends the read
                        next_s.fsm   = line.sda ? ism_pkg::s_wait : ism_pkg::s_ack;
                        next_s.after = ism_pkg::s_tx;
                    end
                end

                default:
                begin
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end

        // A write in the same cycle as the shift-out end keeps the flag set
        if (bus_req.wr && bus_req.addr == ism_pkg::OFF_TXD)
        begin
            next_s.transmit_full_flag = 1'b1;
        end

        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
    end

    // ********************************************************************
    // State register
    // ********************************************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= '{fsm:        ism_pkg::s_idle,
                   after:      ism_pkg::s_idle,
                   mask:       ism_pkg::MASK_RST,
                   own:        ism_pkg::OWN_RST,
                   ctrl:       ism_pkg::CTRL_RST,
                   irq_stat:   ism_pkg::IRQ_RST,
                   irq_mask:   ism_pkg::IRQ_RST,
                   default:    '0};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    // Open drain: the pin is only ever pulled low
    assign sda_out   = 1'b0;
    assign sda_oe    = s.sda_oe;
    assign bus_rdata = s.rdata;
    assign irq       = s.irq;

endmodule // ism_top

// File: tb/ism_master_model.sv
module ism_master_model
(
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Bus master
    // ********
    // Clock idles high between frames
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Long low phase leaves the slave time to let go of its acknowledge
    task automatic bit_x(input logic b, output logic s);
        #150 sda_low = !b;
        #125 scl = 1'b1;
        #120 s = sda;
        #5 scl = 1'b0;
    endtask

    task automatic start_cond();
        #100 sda_low = 1'b0;
        #100 scl = 1'b1;
        #100 sda_low = 1'b1;
        #100 scl = 1'b0;
        #100;
    endtask

    task automatic stop_cond();
        #150 sda_low = 1'b1;
        #125 scl = 1'b1;
        #125 sda_low = 1'b0;
        #200;
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], s);
        bit_x(1'b1, s);
        ack = !s;
    endtask

    task automatic read_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(!give_ack, s);
    endtask
endmodule // ism_master_model

// File: tb/ism_top_assertions.sv
module ism_top_checker
(
    input wire logic                       clock,
    input wire logic                       rst,
    input wire ism_pkg::ism_req_type       bus_req,
    input wire logic [ism_pkg::DATA_W-1:0] bus_rdata,
    input wire logic                       scl_pin,
    input wire logic                       sda_in,
    input wire logic                       sda_out,
    input wire logic                       sda_oe,
    input wire logic                       irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********
    // Checks
    // ********
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    rdata_idle_a:
        assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
        else $error("read data not zero outside a read slot");
    status_bits_a:
        assert property ($past(bus_req.rd) && $past(bus_req.addr) == ism_pkg::OFF_STATUS
            |-> bus_rdata[15:5] == '0 && !(bus_rdata[3] && bus_rdata[4]))
        else $error("status layout wrong");
    mask_upper_a:
        assert property ($past(bus_req.rd) && $past(bus_req.addr) == ism_pkg::OFF_MASK
            |-> bus_rdata[15:10] == '0)
        else $error("mask upper bits not zero");
    mask_back_a:
        assert property (bus_req.wr && bus_req.addr == ism_pkg::OFF_MASK
            ##1 bus_req.rd && bus_req.addr == ism_pkg::OFF_MASK
            |=> bus_rdata[9:0] == $past(bus_req.wdata[9:0], 2))
        else $error("mask readback differs");
    tbf_set_a:
        assert property (bus_req.wr && bus_req.addr == ism_pkg::OFF_TXD
            ##1 bus_req.rd && bus_req.addr == ism_pkg::OFF_STATUS |=> bus_rdata[0])
        else $error("transmit full not set");
    rx_width_a:
        assert property ($past(bus_req.rd) && $past(bus_req.addr) == ism_pkg::OFF_RXD
            |-> bus_rdata[15:8] == '0)
        else $error("receive byte too wide");
    unmapped_zero_a:
        assert property ($past(bus_req.rd) && $past(bus_req.addr) > 4'h7 |-> bus_rdata == '0)
        else $error("unmapped read not zero");
    irq_off_a:
        assert property (bus_req.wr && bus_req.addr == ism_pkg::OFF_IRQ_MASK
            && bus_req.wdata[4:0] == 5'h00 ##1 !bus_req.wr [*2] |-> !irq)
        else $error("interrupt high with all masked");
    oe_still_a:
        assert property (scl_pin && $past(scl_pin) && $past(scl_pin, 2) |-> $stable(sda_oe))
        else $error("data driver moved while clock high");
    open_drain_a:
        assert property (sda_out == 1'b0)
        else $error("data pin driven high");
endmodule // ism_top_checker

bind ism_top ism_top_checker ism_top_checker_i (.clock(clock), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq));

// File: tb/ism_top_bench.sv
module ism_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clock;
    logic                 rst;
    ism_pkg::ism_req_type req;
    logic [15:0]          rdata;
    logic                 scl;
    logic                 m_low;
    logic                 sda_out;
    logic                 sda_oe;
    logic                 irq;
    wire logic            sda;
    int                   n_fail;
    int                   check_count;
    int                   seed;

    // Pulled-up wire
    assign sda = !((sda_oe && !sda_out) || m_low);

    ism_top ism_top_i (.clock(clock), .rst(rst), .bus_req(req), .bus_rdata(rdata),
        .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
    ism_master_model ism_master_model_i (.scl(scl), .sda_low(m_low), .sda(sda));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = !clock;
    end

    // ********
    // Helpers
    // ********
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bw(input logic [3:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        req <= '0;
        @(posedge clock);
    endtask

    task automatic br(input logic [3:0] a, output logic [15:0] v);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clock);
        req <= '0;
        #1 v = rdata;
        @(posedge clock);
    endtask

    function automatic logic hit(input logic [9:0] inc, own, msk, vld);
        return ((inc ^ own) & ~msk & vld) == 10'h000;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #2000000;
        n_fail++;
        results();
    end

    // ********
    // Tests
    // ********
    initial
    begin
        logic [15:0] v;
        logic [15:0] w;
        logic [9:0]  own;
        logic [9:0]  msk;
        logic [9:0]  inc;
        logic [7:0]  d;
        logic [7:0]  b;
        logic        ack;
        logic        ten;
        seed = 32'he3edeb01;
        rst = 1'b1;
        req = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        br(ism_pkg::OFF_STATUS, v);
        chk(v, 16'h0000);
        br(4'hc, v);
        chk(v, 16'h0000);
        br(ism_pkg::OFF_MASK, v);
        chk(v, 16'h0000);
        w = 16'hffff;
        repeat (4)
        begin
            req <= '{1'b1, 1'b0, ism_pkg::OFF_MASK, w};
            @(posedge clock);
            br(ism_pkg::OFF_MASK, v);
            chk(v, w & 16'h03ff);
            w = 16'($random(seed));
        end
        $display("register test done");
        for (int t = 0; t < 12; t++)
        begin
            ten = t[0];
            own = 10'($random(seed));
            msk = (t < 2) ? {10{t[0]}} : 10'($random(seed));
            inc = (t < 2) ? own : own ^ 10'($random(seed) & $random(seed) & $random(seed));
            bw(ism_pkg::OFF_OWN, {6'h00, own});
            bw(ism_pkg::OFF_MASK, {6'h00, msk});
            bw(ism_pkg::OFF_CTRL, {14'h0000, ten, 1'b1});
            ism_master_model_i.start_cond();
            @(posedge clock);
            br(ism_pkg::OFF_STATUS, v);
            chk(v & 16'h0018, 16'h0008);
            if (ten)
            begin
                ism_master_model_i.write_byte({5'h1e, inc[9:8], 1'b0}, ack);
                chk(16'(ack), 16'(hit(inc, own, msk, 10'h300)));
                if (ack)
                    ism_master_model_i.write_byte(inc[7:0], ack);
            end
            else
                ism_master_model_i.write_byte({inc[6:0], 1'b0}, ack);
            chk(16'(ack), 16'(hit(inc, own, msk, ten ? 10'h3ff : 10'h07f)));
            @(posedge clock);
            if (ack)
            begin
                d = 8'($random(seed));
                ism_master_model_i.write_byte(d, ack);
                @(posedge clock);
                chk(16'(ack), 16'h0001);
                br(ism_pkg::OFF_STATUS, v);
                chk(v & 16'h0006, 16'h0002);
                br(ism_pkg::OFF_RXD, v);
                chk(v, {8'h00, d});
                br(ism_pkg::OFF_STATUS, v);
                chk(v & 16'h0002, 16'h0000);
            end
            ism_master_model_i.stop_cond();
            @(posedge clock);
            br(ism_pkg::OFF_STATUS, v);
            chk(v & 16'h0018, 16'h0010);
        end
        $display("address test done");
        bw(ism_pkg::OFF_IRQ_STAT, 16'h001f);
        bw(ism_pkg::OFF_OWN, 16'h0055);
        bw(ism_pkg::OFF_MASK, 16'h0000);
        bw(ism_pkg::OFF_CTRL, 16'h0001);
        d = 8'($random(seed));
        req <= '{1'b1, 1'b0, ism_pkg::OFF_TXD, {8'h00, d}};
        @(posedge clock);
        br(ism_pkg::OFF_STATUS, v);
        chk(v & 16'h0001, 16'h0001);
        ism_master_model_i.start_cond();
        ism_master_model_i.write_byte({7'h55, 1'b1}, ack);
        chk(16'(ack), 16'h0001);
        ism_master_model_i.read_byte(1'b0, b);
        @(posedge clock);
        chk(16'(b), 16'(d));
        br(ism_pkg::OFF_STATUS, v);
        chk(v & 16'h0005, 16'h0004);
        br(ism_pkg::OFF_IRQ_STAT, v);
        chk(v, 16'h0015);
        chk(16'(irq), 16'h0000);
        bw(ism_pkg::OFF_IRQ_MASK, 16'h0010);
        @(posedge clock);
        #1 chk(16'(irq), 16'h0001);
        bw(ism_pkg::OFF_IRQ_STAT, 16'h0010);
        @(posedge clock);
        #1 chk(16'(irq), 16'h0000);
        bw(ism_pkg::OFF_IRQ_MASK, 16'h0000);
        ism_master_model_i.stop_cond();
        $display("transmit test done");
        results();
    end
endmodule // ism_top_bench
